// ---- asc_ctrl.sv ----
// Control, register file and sequencer of the 8-bit successive approximation converter.
//
// Design decision made here: the address-and-strobe port.
module asc_ctrl (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire asc_pkg::asc_bus_req_s bus_i,
  output logic [7:0] rdata_o,
  input wire logic ext_trigger_pin_i,
  input wire logic comp_i,
  output logic [7:0] dac_code_o,
  output asc_pkg::asc_ana_s ana_o,
  output logic busy_o,
  output logic irq_o
);

  asc_pkg::asc_ctl_s st_reg;
  asc_pkg::asc_ctl_s st_next;
  logic trig_edge;
  logic sar_load;
  logic sar_step;
  logic [7:0] sar_code;
  logic wr_start;
  logic wr_stop;
  logic start_now;
  logic [1:0] int_set;
  logic [1:0] int_clr;

  // Decodes the channel field to one enable per analog input.
  function automatic logic [7:0] ch_decode(input logic [3:0] ch);
    logic [7:0] en;
    en = 8'h00;
    if (ch[3:2] == asc_pkg::CH_BANK_LO) begin
      en[{1'b0, ch[1:0]}] = 1'b1;
    end else if (ch[3:2] == asc_pkg::CH_BANK_HI) begin
      en[{1'b1, ch[1:0]}] = 1'b1;
    end
    return en;
  endfunction

  asc_edge_det u_edge (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i(ext_trigger_pin_i),
    .rise_sel_i(st_reg.edge_rise),
    .edge_o(trig_edge)
  );

  asc_sar #(
    .W(asc_pkg::RESULT_W)
  ) u_sar (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .load_i(sar_load),
    .step_i(sar_step),
    .comp_i(comp_i),
    .code_o(sar_code)
  );

  // Register writes, sequencer, interrupt flags and read data.
  always_comb begin
    st_next = st_reg;
    sar_load = 1'b0;
    sar_step = 1'b0;
    int_set = 2'h0;
    int_clr = 2'h0;
    wr_start = bus_i.we && (bus_i.addr == asc_pkg::ADDR_START);
    wr_stop = wr_start && !bus_i.wdata[asc_pkg::START_FLAG_BIT];
    start_now = 1'b0;

    // Software start, or the accepted trigger edge, when idle.
    if (st_reg.state == asc_pkg::ST_IDLE) begin
      if (wr_start && bus_i.wdata[asc_pkg::START_FLAG_BIT]) begin
        start_now = 1'b1;
      end else if (trig_edge && st_reg.mode[asc_pkg::MODE_TRIG_BIT]) begin
        start_now = 1'b1;
        int_set[asc_pkg::INT_TRIG_BIT] = 1'b1;
      end
    end

    // Sequencer; a write of 1 while busy falls through untouched.
    case (st_reg.state)
      asc_pkg::ST_IDLE: begin
        if (start_now) begin
          st_next.state = asc_pkg::ST_SAMPLE;
          st_next.start_flag = 1'b1;
          st_next.speed_lat = st_reg.mode[asc_pkg::MODE_SPEED_BIT];
          st_next.tmr = st_reg.mode[asc_pkg::MODE_SPEED_BIT] ?
            asc_pkg::FAST_SAMPLE_CYC - 4'h1 : asc_pkg::SLOW_SAMPLE_CYC - 4'h1;
          st_next.ana.sample = 1'b1;
          st_next.ana.chan_en = ch_decode(st_reg.mode[3:0]);
          sar_load = 1'b1;
        end
      end
      asc_pkg::ST_SAMPLE: begin
        if (st_reg.tmr == 4'h0) begin
          st_next.state = asc_pkg::ST_CONVERT;
          st_next.ana.sample = 1'b0;
          st_next.bit_cnt = 3'h0;
          st_next.tmr = st_reg.speed_lat ? asc_pkg::FAST_BIT_CYC - 4'h1 : asc_pkg::SLOW_BIT_CYC - 4'h1;
        end else begin
          st_next.tmr = st_reg.tmr - 4'h1;
        end
      end
      asc_pkg::ST_CONVERT: begin
        if (st_reg.tmr == 4'h0) begin
          sar_step = 1'b1;
          st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
          st_next.tmr = st_reg.speed_lat ? asc_pkg::FAST_BIT_CYC - 4'h1 : asc_pkg::SLOW_BIT_CYC - 4'h1;
          if (st_reg.bit_cnt == 3'h7) begin
            st_next.state = asc_pkg::ST_STORE;
          end
        end else begin
          st_next.tmr = st_reg.tmr - 4'h1;
        end
      end
      asc_pkg::ST_STORE: begin
        st_next.state = asc_pkg::ST_IDLE;
        st_next.result = sar_code;
        st_next.start_flag = 1'b0;
        st_next.ana.chan_en = 8'h00;
        int_set[asc_pkg::INT_CONV_END_BIT] = 1'b1;
      end
      default: begin
        st_next.state = asc_pkg::ST_IDLE;
        st_next.start_flag = 1'b0;
      end
    endcase

    // Writing 0 to the flag aborts a running conversion; before the store step it leaves no result.
    if (wr_stop && st_reg.state != asc_pkg::ST_IDLE) begin
      st_next.state = asc_pkg::ST_IDLE;
      st_next.start_flag = 1'b0;
      st_next.ana = '0;
    end

    // Mode writes keep the fixed ones; interrupt enable and edge select.
    if (bus_i.we) begin
      case (bus_i.addr)
        asc_pkg::ADDR_MODE: st_next.mode = bus_i.wdata | asc_pkg::MODE_FIXED;
        asc_pkg::ADDR_INT_CLR: int_clr = bus_i.wdata[1:0];
        asc_pkg::ADDR_INT_EN: st_next.int_en = bus_i.wdata[1:0];
        asc_pkg::ADDR_EDGE: st_next.edge_rise = bus_i.wdata[asc_pkg::EDGE_RISE_BIT];
        default: st_next.int_en = st_next.int_en;
      endcase
    end

    // Sticky flags: a new event wins over a clear in the same cycle.
    st_next.int_stat = (st_reg.int_stat & ~int_clr) | int_set;
    st_next.irq = |(st_next.int_stat & st_next.int_en);

    // Read data stand in the cycle after the read strobe only.
    st_next.rdata = 8'h00;
    if (bus_i.re) begin
      case (bus_i.addr)
        asc_pkg::ADDR_MODE: st_next.rdata = st_reg.mode | asc_pkg::MODE_FIXED;
        asc_pkg::ADDR_RESULT: st_next.rdata = st_reg.result;
        asc_pkg::ADDR_START: st_next.rdata = {st_reg.start_flag, asc_pkg::START_FIXED[6:0]};
        asc_pkg::ADDR_INT_STAT: st_next.rdata = {6'h00, st_reg.int_stat};
        asc_pkg::ADDR_INT_EN: st_next.rdata = {6'h00, st_reg.int_en};
        asc_pkg::ADDR_EDGE: st_next.rdata = {7'h00, st_reg.edge_rise};
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset keeps whatever the result register held.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg.state <= asc_pkg::ST_IDLE;
      st_reg.mode <= asc_pkg::MODE_RST;
      st_reg.start_flag <= asc_pkg::START_RST[asc_pkg::START_FLAG_BIT];
      st_reg.speed_lat <= 1'b0;
      st_reg.result <= st_reg.result;
      st_reg.int_stat <= 2'h0;
      st_reg.int_en <= asc_pkg::INT_EN_RST;
      st_reg.edge_rise <= asc_pkg::EDGE_SEL_RST;
      st_reg.tmr <= 4'h0;
      st_reg.bit_cnt <= 3'h0;
      st_reg.rdata <= 8'h00;
      st_reg.irq <= 1'b0;
      st_reg.ana <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register; the ladder code comes from the SAR register.
  assign rdata_o = st_reg.rdata;
  assign dac_code_o = sar_code;
  assign ana_o = st_reg.ana;
  assign busy_o = st_reg.start_flag;
  assign irq_o = st_reg.irq;

  // Helper counter of cycles spent away from idle, read only by checks.
  logic [5:0] busy_cnt;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || st_reg.state == asc_pkg::ST_IDLE) begin
      busy_cnt <= 6'h00;
    end else if (ce_i) begin
      busy_cnt <= busy_cnt + 6'h01;
    end
  end

  // Set by the first store after reset, so the unknown power-up result is never compared.
  logic res_known;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      res_known <= 1'b0;
    end else if (ce_i && st_reg.state == asc_pkg::ST_STORE) begin
      res_known <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Store step of a conversion and its visible effects.
  sequence s_store;
    ce_i && st_reg.state == asc_pkg::ST_STORE;
  endsequence

  sequence s_done(logic [7:0] code);
    !st_reg.start_flag && st_reg.result == code && st_reg.int_stat[asc_pkg::INT_CONV_END_BIT];
  endsequence

  property p_reset_mode;
    $rose(rst_n_i) |-> st_reg.mode == 8'h30 && !st_reg.start_flag && st_reg.state == asc_pkg::ST_IDLE;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode or start flag wrong after reset");

  property p_period;
    s_store |-> busy_cnt == (st_reg.speed_lat ? 6'd30 : 6'd61);
  endproperty
  a_period: assert property (p_period) else $error("conversion period length wrong");

  property p_complete;
    logic [7:0] c;
    (s_store, c = sar_code) |=> s_done(c) ##1 (st_reg.result == c);
  endproperty
  a_complete: assert property (p_complete) else $error("result or flag wrong after completion");

  property p_irq;
    s_store ##1 st_reg.int_en[asc_pkg::INT_CONV_END_BIT] |-> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled completion raised no interrupt");

  property p_hold;
    res_known && ce_i && st_reg.state == asc_pkg::ST_IDLE ##1 st_reg.state == asc_pkg::ST_IDLE
      |-> $stable(st_reg.result);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed while idle");

  property p_stop;
    ce_i && wr_stop && st_reg.state != asc_pkg::ST_IDLE |=> st_reg.state == asc_pkg::ST_IDLE && !busy_o;
  endproperty
  a_stop: assert property (p_stop) else $error("write of zero did not stop conversion");

  property p_no_restart;
    ce_i && wr_start && !wr_stop && st_reg.state == asc_pkg::ST_CONVERT
      |=> st_reg.state != asc_pkg::ST_SAMPLE && $stable(st_reg.speed_lat);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("running conversion was restarted");

  property p_trigger;
    ce_i && trig_edge && st_reg.state == asc_pkg::ST_IDLE && !wr_start
      |=> (busy_o == $past(st_reg.mode[asc_pkg::MODE_TRIG_BIT]));
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger edge handling wrong");

  property p_fixed_bits;
    ce_i && bus_i.re && bus_i.addr == asc_pkg::ADDR_MODE |=> rdata_o[5:4] == 2'h3;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("mode reserved bits not read as one");

  property p_start_read;
    ce_i && bus_i.re && bus_i.addr == asc_pkg::ADDR_START
      |=> rdata_o == {$past(busy_o), 7'h7f};
  endproperty
  a_start_read: assert property (p_start_read) else $error("start register readback wrong");

  // Invariants between the sequencer state and the visible outputs.
  property p_busy_flag;
    busy_o == (st_reg.state != asc_pkg::ST_IDLE);
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("start flag disagrees with sequencer state");

  property p_idle_ana;
    st_reg.state == asc_pkg::ST_IDLE |-> ana_o == '0;
  endproperty
  a_idle_ana: assert property (p_idle_ana) else $error("analog controls active while idle");

  property p_sample_phase;
    ana_o.sample == (st_reg.state == asc_pkg::ST_SAMPLE);
  endproperty
  a_sample_phase: assert property (p_sample_phase) else $error("sample control outside the sample phase");

  // A start loads the first trial code and latches the speed.
  property p_start_code;
    ce_i && start_now |=> busy_o && dac_code_o == 8'h80 && st_reg.state == asc_pkg::ST_SAMPLE;
  endproperty
  a_start_code: assert property (p_start_code) else $error("start did not load the first trial code");

  property p_speed_lat;
    ce_i && start_now |=> st_reg.speed_lat == $past(st_reg.mode[asc_pkg::MODE_SPEED_BIT]);
  endproperty
  a_speed_lat: assert property (p_speed_lat) else $error("speed not latched at start");

  property p_trig_status;
    ce_i && trig_edge && st_reg.mode[asc_pkg::MODE_TRIG_BIT] && st_reg.state == asc_pkg::ST_IDLE && !wr_start
      |=> st_reg.int_stat[asc_pkg::INT_TRIG_BIT];
  endproperty
  a_trig_status: assert property (p_trig_status) else $error("trigger start not flagged");

  // An abort in the sample or convert phase leaves the stored result and the completion flag alone.
  property p_abort_keep;
    res_known && ce_i && wr_stop && (st_reg.state == asc_pkg::ST_SAMPLE || st_reg.state == asc_pkg::ST_CONVERT)
      |=> $stable(st_reg.result) && $stable(st_reg.int_stat[asc_pkg::INT_CONV_END_BIT]);
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("abort changed result or completion flag");

  property p_irq_level;
    irq_o == |(st_reg.int_stat & st_reg.int_en);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level disagrees with flags");

endmodule

// ---- asc_pkg.sv ----
// Shared constants and types for the converter sequencer control block.
package asc_pkg;

  // Register bus widths and register byte addresses.
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [15:0] ADDR_MODE = 16'hffc4;
  localparam logic [15:0] ADDR_RESULT = 16'hffc5;
  localparam logic [15:0] ADDR_START = 16'hffc6;
  localparam logic [15:0] ADDR_INT_STAT = 16'hffc8;
  localparam logic [15:0] ADDR_INT_CLR = 16'hffc9;
  localparam logic [15:0] ADDR_INT_EN = 16'hffca;
  localparam logic [15:0] ADDR_EDGE = 16'hffcb;

  // Mode register layout and reset value.
  localparam logic [7:0] MODE_RST = 8'h30;
  localparam logic [7:0] MODE_FIXED = 8'h30;
  localparam int unsigned MODE_SPEED_BIT = 7;
  localparam int unsigned MODE_TRIG_BIT = 6;
  localparam int unsigned MODE_CH_LSB = 0;
  localparam int unsigned MODE_CH_W = 4;

  // Start register layout and reset value.
  localparam logic [7:0] START_RST = 8'h7f;
  localparam logic [7:0] START_FIXED = 8'h7f;
  localparam int unsigned START_FLAG_BIT = 7;

  // Interrupt status, enable and edge-select layouts.
  localparam int unsigned INT_W = 2;
  localparam int unsigned INT_CONV_END_BIT = 0;
  localparam int unsigned INT_TRIG_BIT = 1;
  localparam logic [1:0] INT_EN_RST = 2'h0;
  localparam int unsigned EDGE_RISE_BIT = 0;
  localparam logic EDGE_SEL_RST = 1'b0;

  // Channel field codes: upper two bits choose the input bank.
  localparam logic [1:0] CH_BANK_LO = 2'h1;
  localparam logic [1:0] CH_BANK_HI = 2'h2;

  // Conversion timing in system clocks: sample phase, eight bit phases, store.
  localparam int unsigned RESULT_W = 8;
  localparam int unsigned CHAN_N = 8;
  localparam int unsigned TMR_W = 4;
  localparam int unsigned SLOW_PERIOD = 62;
  localparam int unsigned FAST_PERIOD = 31;
  localparam logic [3:0] SLOW_BIT_CYC = 4'h6;
  localparam logic [3:0] FAST_BIT_CYC = 4'h3;
  localparam logic [3:0] SLOW_SAMPLE_CYC = 4'(SLOW_PERIOD - 1 - RESULT_W * 6);
  localparam logic [3:0] FAST_SAMPLE_CYC = 4'(FAST_PERIOD - 1 - RESULT_W * 3);

  // Sequencer states, Gray coded along idle, sample, convert, store.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_CONVERT = 2'h3,
    ST_STORE = 2'h2
  } asc_state_e;

  // One register bus request.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } asc_bus_req_s;

  // Controls towards the analog front end.
  typedef struct packed {
    logic sample;
    logic [7:0] chan_en;
  } asc_ana_s;

  // Complete state of the control block.
  typedef struct packed {
    asc_state_e state;
    logic [7:0] mode;
    logic start_flag;
    logic speed_lat;
    logic [7:0] result;
    logic [1:0] int_stat;
    logic [1:0] int_en;
    logic edge_rise;
    logic [3:0] tmr;
    logic [2:0] bit_cnt;
    logic [7:0] rdata;
    logic irq;
    asc_ana_s ana;
  } asc_ctl_s;

endpackage

// ---- asc_edge_det.sv ----
// Trigger edge detector with selectable polarity.
module asc_edge_det (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic pin_i,
  input wire logic rise_sel_i,
  output logic edge_o
);

  typedef struct packed {
    logic prev;
  } asc_edge_s;

  asc_edge_s st_reg;
  asc_edge_s st_next;

  // Only the chosen edge produces a pulse; the other one is dropped.
  always_comb begin
    st_next = st_reg;
    st_next.prev = pin_i;
    edge_o = rise_sel_i ? (pin_i & ~st_reg.prev) : (~pin_i & st_reg.prev);
  end

  // The pin idles high, so a high level seen right after reset is no edge.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg.prev <= 1'b1;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

endmodule

// ---- asc_sar.sv ----
// Successive approximation register that drives the ladder code.
module asc_sar #(
  parameter int unsigned W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic step_i,
  input wire logic comp_i,
  output logic [W-1:0] code_o
);

  typedef struct packed {
    logic [W-1:0] code;
    logic [W-1:0] mask;
  } asc_sar_s;

  asc_sar_s st_reg;
  asc_sar_s st_next;
  logic [W-1:0] kept;

  // Each step keeps or drops the trial bit, then tries the next lower one.
  always_comb begin
    st_next = st_reg;
    kept = comp_i ? st_reg.code : (st_reg.code & ~st_reg.mask);
    if (load_i) begin
      st_next.mask = {1'b1, {(W - 1){1'b0}}};
      st_next.code = {1'b1, {(W - 1){1'b0}}};
    end else if (step_i) begin
      st_next.mask = st_reg.mask >> 1;
      st_next.code = kept | (st_reg.mask >> 1);
    end
  end

  // Register of the approximation.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign code_o = st_reg.code;

endmodule

// ---- asc_ana_model.sv ----
// Behavioural analog front end: eight input levels, the input multiplexer and the comparator.
module asc_ana_model (
  input wire logic [7:0][7:0] levels_i,
  input wire asc_pkg::asc_ana_s ana_i,
  input wire logic [7:0] dac_code_i,
  output logic comp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lvl;

  // The enabled input reaches the comparator; with no input enabled the node sits at ground.
  always_comb begin
    lvl = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (ana_i.chan_en[i]) begin
        lvl = levels_i[i];
      end
    end
    comp_o = (lvl >= dac_code_i);
  end
endmodule

// ---- adc_sequencer_control_tb.sv ----
// Self-checking testbench of the converter sequencer control block.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("ERROR %0t: got %h expected %h", $time, g, e); end end

module adc_sequencer_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pin = 1'b1; // The trigger pin idles high, as the detector assumes after reset.
  logic ce = 1'b1;
  int n_smp;
  asc_pkg::asc_bus_req_s bus = '0;
  logic [7:0] rdata_o;
  logic [7:0] dac_code_o;
  asc_pkg::asc_ana_s ana_o;
  logic busy_o;
  logic irq_o;
  logic comp;
  logic [7:0][7:0] levels = '0;
  logic re_d = 1'b0;
  logic [7:0] exp_q [$];
  logic [7:0] exp_v;
  logic [7:0] en_seen;
  logic [31:0] rnd = 32'h93ac734f;
  int miscompares = 0;
  int n_tests = 0;
  int n;

  asc_ctrl dut_u (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce),
    .bus_i(bus),
    .rdata_o(rdata_o),
    .ext_trigger_pin_i(pin),
    .comp_i(comp),
    .dac_code_o(dac_code_o),
    .ana_o(ana_o),
    .busy_o(busy_o),
    .irq_o(irq_o)
  );

  asc_ana_model model_u (
    .levels_i(levels),
    .ana_i(ana_o),
    .dac_code_i(dac_code_o),
    .comp_o(comp)
  );

  // The clock toggles every half period of 5 ns.
  always #5 clk_i = ~clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic asc_pkg::asc_bus_req_s req(input logic [15:0] a, input logic [7:0] d, input logic w);
    return '{addr: a, wdata: d, we: w, re: ~w};
  endfunction

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A bus cycle holds its strobe one cycle, then leaves one idle cycle so no signal is driven twice in a step.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus <= req(a, d, 1'b1);
    @(posedge clk_i);
    bus <= '0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus <= req(a, 8'h00, 1'b0);
    @(posedge clk_i);
    bus <= '0;
    @(posedge clk_i);
  endtask

  // Sets the mode while idle, starts by software or by pin, optionally writes the start register mid-run.
  task automatic conv(input logic [7:0] mode, input logic by_pin, input int poke_at, input logic [7:0] poke);
    wr(asc_pkg::ADDR_MODE, mode);
    if (by_pin) begin
      pin <= ~pin;
    end else begin
      bus <= req(asc_pkg::ADDR_START, 8'h80, 1'b1);
    end
    n = 0;
    n_smp = 0;
    en_seen = 8'h00;
    repeat (100) begin
      @(posedge clk_i);
      bus <= (n == poke_at) ? req(asc_pkg::ADDR_START, poke, 1'b1) : '0;
      @(negedge clk_i);
      if (busy_o !== 1'b1) break;
      if (n == 0) en_seen = ana_o.chan_en;
      if (ana_o.sample) n_smp++;
      n++;
    end
    @(posedge clk_i);
  endtask

  // Read data stand in the cycle after the strobe; the oldest note is compared there.
  always @(posedge clk_i) re_d <= bus.re;
  always @(negedge clk_i) begin
    if (re_d) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata_o, exp_v)
    end
  end

  // A hang counts as a mismatch and ends the run.
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end

  // Main sequence of scenarios.
  initial begin
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      levels[i] <= rnd[7:0];
    end
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(asc_pkg::ADDR_MODE, asc_pkg::MODE_RST);
    rd(asc_pkg::ADDR_START, asc_pkg::START_RST);
    rd(asc_pkg::ADDR_INT_EN, 8'h00);
    rd(16'hffd0, 8'h00);
    ce <= 1'b0;
    wr(asc_pkg::ADDR_MODE, 8'h8f);
    ce <= 1'b1;
    rd(asc_pkg::ADDR_MODE, asc_pkg::MODE_RST);
    wr(asc_pkg::ADDR_MODE, 8'h0f);
    rd(asc_pkg::ADDR_MODE, 8'h3f);
    wr(asc_pkg::ADDR_START, 8'h00);
    rd(asc_pkg::ADDR_START, 8'h7f);
    wr(asc_pkg::ADDR_INT_EN, 8'h01);
    for (int c = 0; c < 8; c++) begin
      conv({c[0], 3'b011, 4'(4 + c)}, 1'b0, (c == 3) ? 10 : -1, 8'h80);
      `CHK(n, c[0] ? 31 : 62)
      `CHK(en_seen, 8'h01 << c)
      `CHK(n_smp, c[0] ? 6 : 13)
      `CHK(irq_o, 1'b1)
      rd(asc_pkg::ADDR_RESULT, levels[c]);
      rd(asc_pkg::ADDR_INT_STAT, 8'h01);
      wr(asc_pkg::ADDR_INT_CLR, 8'h03);
      rd(asc_pkg::ADDR_INT_STAT, 8'h00);
    end
    `CHK(irq_o, 1'b0)
    conv(8'h30, 1'b0, 5, 8'h00);
    `CHK(n, 6)
    rd(asc_pkg::ADDR_INT_STAT, 8'h00);
    rd(asc_pkg::ADDR_RESULT, levels[7]);
    wr(asc_pkg::ADDR_INT_EN, 8'h00);
    conv(8'h33, 1'b0, -1, 8'h00);
    `CHK(n, 62)
    `CHK(irq_o, 1'b0)
    rd(asc_pkg::ADDR_RESULT, 8'h00);
    rd(asc_pkg::ADDR_INT_STAT, 8'h01);
    wr(asc_pkg::ADDR_INT_CLR, 8'h03);
    conv(8'hb4, 1'b1, -1, 8'h00);
    `CHK(n, 0)
    conv(8'hf4, 1'b1, -1, 8'h00);
    `CHK(n, 0)
    conv(8'hf4, 1'b1, -1, 8'h00);
    `CHK(n, 31)
    `CHK(en_seen, 8'h01)
    rd(asc_pkg::ADDR_RESULT, levels[0]);
    rd(asc_pkg::ADDR_INT_STAT, 8'h03);
    rd(asc_pkg::ADDR_START, 8'h7f);
    wr(asc_pkg::ADDR_INT_CLR, 8'h03);
    wr(asc_pkg::ADDR_EDGE, 8'h01);
    rd(asc_pkg::ADDR_EDGE, 8'h01);
    conv(8'hf4, 1'b1, -1, 8'h00);
    `CHK(n, 31)
    rd(asc_pkg::ADDR_INT_STAT, 8'h03);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(asc_pkg::ADDR_RESULT, levels[0]);
    rd(asc_pkg::ADDR_MODE, 8'h30);
    repeat (2) @(posedge clk_i);
    give_verdict();
  end
endmodule
